/* File: ufm_pkg.sv */
// Shared constants for the one-way serial write link.
// Assumes both ends run on a 125 MHz reference clock.
package ufm_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_MHZ   = 125;
  localparam int LINK_MAX_KHZ  = 5000;
  // Shortest half period the master may make, rounded up to whole cycles.
  localparam int HALF_MIN_CYC  = (REF_CLK_MHZ * 1000 + 2 * LINK_MAX_KHZ - 1) / (2 * LINK_MAX_KHZ);
  localparam int HALF_CYC_DEF  = 16;
  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  localparam int BYTE_BITS     = 8;
  localparam int SLOT_BITS     = 9;
  localparam logic NINTH_LEVEL = 1'b1;
  localparam logic LINE_IDLE   = 1'b1;
endpackage : ufm_pkg

/* File: ufm_link_if.sv */
// Two-wire one-way link between master and receiver.
// Both wires are driven only by the master; idle level is high.
`timescale 1ns/1ps
interface ufm_link_if;
  logic serial_clock_line;
  logic serial_data_line;
  modport master   (output serial_clock_line, output serial_data_line);
  modport receiver (input serial_clock_line, input serial_data_line);
endinterface : ufm_link_if

/* File: ufm_master.sv */
// Master end: sends START, bytes each with a ninth bit of one, STOP.
// Assumes the user holds byte_valid with byte_data until byte_ready.
`timescale 1ns/1ps
module ufm_master #(
  parameter int HALF_CYC = ufm_pkg::HALF_CYC_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  ufm_link_if.master      link,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       byte_last,
  output logic            byte_ready,
  output logic            busy
);
  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  // The half period must keep the link at or under 5 MHz and fit the 8-bit counter.
  if (HALF_CYC < ufm_pkg::HALF_MIN_CYC || HALF_CYC > 256)
  begin : g_bad_half
    $error("HALF_CYC outside the range that the link and the counter allow");
  end

  typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_HOLD, M_STOPL, M_STOPH} mst_t;
  mst_t       st_ff;
  logic [7:0] cnt_ff;
  logic [3:0] bit_ff;
  logic [8:0] sh_ff;
  logic       last_ff;
  logic       scl_ff;
  logic       sda_ff;
  wire        tick = (cnt_ff == 8'(HALF_CYC - 1));

  assign link.serial_clock_line = scl_ff; // [RULE2]
  assign link.serial_data_line  = sda_ff;
  assign byte_ready = (st_ff == M_IDLE) || (st_ff == M_HOLD);
  assign busy       = (st_ff != M_IDLE);

  always_ff @(posedge ref_clk)
    if (rst || st_ff == M_IDLE || st_ff == M_HOLD || tick) cnt_ff <= 8'h00;
    else cnt_ff <= cnt_ff + 8'h01;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_ff   <= M_IDLE;
      scl_ff  <= ufm_pkg::LINE_IDLE; // [RULE5]
      sda_ff  <= ufm_pkg::LINE_IDLE;
      bit_ff  <= 4'h0;
      sh_ff   <= 9'h1FF;
      last_ff <= 1'b0;
    end
    else
      case (st_ff)
        M_IDLE:
          if (byte_valid)
          begin
            sda_ff  <= 1'b0; // [RULE6]
            sh_ff   <= {byte_data, ufm_pkg::NINTH_LEVEL}; // [RULE9]
            last_ff <= byte_last;
            bit_ff  <= 4'h0;
            st_ff   <= M_START;
          end
        M_START:
          if (tick)
          begin
            scl_ff <= 1'b0;
            st_ff  <= M_LOW;
          end
        M_LOW:
          if (tick)
          begin
            scl_ff <= 1'b1;
            st_ff  <= M_HIGH;
          end
          else if (cnt_ff == 8'h00)
            sda_ff <= sh_ff[8]; // Data changes only while clock low. [RULE4] [RULE3]
        M_HIGH:
          if (tick)
          begin
            scl_ff <= 1'b0;
            sh_ff  <= {sh_ff[7:0], 1'b1};
            if (bit_ff == 4'(ufm_pkg::SLOT_BITS - 1)) // [RULE10]
            begin
              bit_ff <= 4'h0;
              st_ff  <= last_ff ? M_STOPL : M_HOLD;
            end
            else
            begin
              bit_ff <= bit_ff + 4'h1;
              st_ff  <= M_LOW;
            end
          end
        // The clock waits low between bytes, so a slow source never cuts the frame.
        M_HOLD:
          if (byte_valid)
          begin
            sh_ff   <= {byte_data, ufm_pkg::NINTH_LEVEL}; // [RULE9]
            last_ff <= byte_last;
            st_ff   <= M_LOW; // No limit on bytes per frame. [RULE8]
          end
        M_STOPL:
          if (tick)
          begin
            scl_ff <= 1'b1;
            st_ff  <= M_STOPH;
          end
          else if (cnt_ff == 8'h00)
            sda_ff <= 1'b0;
        M_STOPH:
          if (tick)
          begin
            sda_ff <= 1'b1; // [RULE7]
            st_ff  <= M_IDLE;
          end
        default: st_ff <= M_IDLE;
      endcase
  end

endmodule : ufm_master

/* File: ufm_receiver.sv */
// Receiver end: samples the link, finds START/STOP, assembles bytes.
// Assumes the link lines are asynchronous to ref_clk.
//
// Contract
// [RULE1] Receive only, never drive data line.
// [RULE2] One-way two-line link up to 5 MHz.
// [RULE3] One data bit per clock pulse.
// [RULE4] Data steady while clock high.
// [RULE5] Both lines high means idle bus.
// [RULE6] Data falls with clock high: START.
// [RULE7] Data rises with clock high: STOP.
// [RULE8] Unlimited bytes between START and STOP.
// [RULE9] Ninth bit is one, not data.
// [RULE10] Master gives nine clock pulses per byte.
// [RULE11] Master sets auto-increment bits before bursts.
// [RULE12] No acknowledge is ever driven.
// [RULE13] Synchronise lines, sample on clock rise.
`timescale 1ns/1ps
module ufm_receiver (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  ufm_link_if.receiver    link,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            frame_start,
  output logic            frame_stop,
  output logic            in_frame,
  output logic            ninth_error
);
  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic       scl_d_ff;
  logic       sda_d_ff;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], link.serial_clock_line}; // [RULE13]
      sda_sync_ff <= {sda_sync_ff[0], link.serial_data_line};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
    end
  end
  wire scl      = scl_sync_ff[1];
  wire sda      = sda_sync_ff[1];
  wire scl_rise = scl & ~scl_d_ff;
  // Both lines pass through equal two-flop synchronisers, so an edge of data while
  // clock is stable high is a control condition, never a bit.
  wire start_c  = scl & scl_d_ff & sda_d_ff & ~sda; // [RULE6] [RULE4]
  wire stop_c   = scl & scl_d_ff & ~sda_d_ff & sda; // [RULE7] [RULE5]

  // ---------------------------------------------------------------
  // Byte assembly
  // ---------------------------------------------------------------
  logic       act_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      act_ff      <= 1'b0;
      bit_ff      <= 4'h0;
      sh_ff       <= 8'h00;
      rx_data     <= 8'h00;
      rx_valid    <= 1'b0;
      frame_start <= 1'b0;
      frame_stop  <= 1'b0;
      ninth_error <= 1'b0;
    end
    else
    begin
      rx_valid    <= 1'b0;
      frame_start <= start_c;
      frame_stop  <= stop_c & act_ff;
      ninth_error <= 1'b0;
      if (start_c)
      begin
        act_ff <= 1'b1;
        bit_ff <= 4'h0;
      end
      else if (stop_c)
        act_ff <= 1'b0;
      else if (act_ff && scl_rise) // [RULE3]
      begin
        if (bit_ff == 4'(ufm_pkg::BYTE_BITS)) // [RULE9] [RULE10]
        begin
          bit_ff      <= 4'h0; // Next byte, no length limit. [RULE8]
          ninth_error <= (sda != ufm_pkg::NINTH_LEVEL);
        end
        else
        begin
          sh_ff  <= {sh_ff[6:0], sda};
          bit_ff <= bit_ff + 4'h1;
          if (bit_ff == 4'(ufm_pkg::BYTE_BITS - 1))
          begin
            rx_data  <= {sh_ff[6:0], sda};
            rx_valid <= 1'b1;
          end
        end
      end
    end
  end
  // No output toward the data line exists at all. [RULE1] [RULE12]
  assign in_frame = act_ff;
endmodule : ufm_receiver

/* File: ufm_link_props.sv */
// Checker of the link wires that the master drives.
// Assumes the master half period lies between 13 and 16 reference cycles.
`timescale 1ns/1ps
module ufm_link_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_clock_line,
  input wire logic serial_data_line
);
  wire logic  c = serial_clock_line;
  wire logic  d = serial_data_line;
  logic       c_ff;
  logic [3:0] n_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk) c_ff <= c;
  // Clock rises within the current nine-pulse slot; a STOP follows one more rise.
  always_ff @(posedge ref_clk)
    if (rst || (c && $fell(d))) n_ff <= 4'h0;
    else if (c && !c_ff) n_ff <= (n_ff == 4'h8) ? 4'h0 : n_ff + 4'h1;
  AST_IDLE: assert property ($fell(rst) |-> c && d) else $error("idle");
  AST_START: assert property (c && $fell(d) |-> ##[1:16] !c) else $error("start");
  AST_HIGH: assert property ($rose(c) |-> c[*8]) else $error("high");
  AST_LOW: assert property ($fell(c) |-> !c[*8]) else $error("low");
  AST_STEADY: assert property ($rose(c) |=> $stable(d)[*8]) else $error("steady");
  AST_SETUP: assert property (!c && $changed(d) |-> ##[1:16] $rose(c)) else $error("setup");
  AST_NINTH: assert property (c && !c_ff && n_ff == 4'h8 |-> d) else $error("ninth");
  AST_STOP: assert property (c && $rose(d) |-> n_ff == 4'h1) else $error("count");
  cover property (c && $fell(d));
  cover property (c && $rose(d));
  cover property (c && !c_ff && n_ff == 4'h8);
endmodule : ufm_link_props

/* File: tb_ufm_write_only_serial_receiver.sv */
// Bench: master to receiver, and a second receiver on a hand-driven link.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_ufm_write_only_serial_receiver;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       valid = 1'b0;
  logic       last = 1'b1;
  logic [7:0] data = 8'h00;
  logic       ready;
  logic       busy;
  logic       sc2 = 1'b1;
  logic       sd2 = 1'b1;
  logic [7:0] rd [2];
  logic [1:0] rv, fs, fp, fr, ne;
  logic [7:0] q [2][$];
  int         cnt [2][3];
  int         error_cnt = 0;
  int         num_checks = 0;
  ufm_link_if link ();
  ufm_link_if link2 ();
  assign link2.serial_clock_line = sc2;
  assign link2.serial_data_line  = sd2;
  always #4 ref_clk = ~ref_clk;
  ufm_master #(.HALF_CYC(13)) ufm_master_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .byte_valid(valid),
    .byte_data(data), .byte_last(last), .byte_ready(ready), .busy(busy));
  ufm_receiver ufm_receiver_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .rx_data(rd[0]), .rx_valid(rv[0]),
    .frame_start(fs[0]), .frame_stop(fp[0]), .in_frame(fr[0]), .ninth_error(ne[0]));
  ufm_receiver ufm_receiver_inst2 (.ref_clk(ref_clk), .rst(rst), .link(link2), .rx_data(rd[1]), .rx_valid(rv[1]),
    .frame_start(fs[1]), .frame_stop(fp[1]), .in_frame(fr[1]), .ninth_error(ne[1]));
  ufm_link_props ufm_link_props_inst (.ref_clk(ref_clk), .rst(rst), .serial_clock_line(link.serial_clock_line),
    .serial_data_line(link.serial_data_line));
  always @(posedge ref_clk)
    for (int i = 0; i < 2; i++)
    begin
      cnt[i][0] += fs[i];
      cnt[i][1] += fp[i];
      cnt[i][2] += ne[i];
      if (rv[i]) q[i].push_back(rd[i]);
    end
  // The request stands until the edge at which ready is seen high.
  task automatic put(input logic [7:0] b, input logic l);
    valid <= 1'b1;
    data  <= b;
    last  <= l;
    @(posedge ref_clk);
    while (!ready) @(posedge ref_clk);
    valid <= 1'b0;
    @(posedge ref_clk);
  endtask : put
  task automatic drain;
    `CHK("ready in frame", 1'b0, ready)
    while (busy) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    `CHK("ready idle", 1'b1, ready)
  endtask : drain
  task automatic t_master;
    logic [7:0] v [4] = '{8'hA5, 8'h00, 8'hFF, 8'h5A};
    logic [7:0] w [3] = '{8'h3C, 8'h96, 8'h0F};
    logic [7:0] got;
    for (int i = 0; i < 4; i++)
    begin
      put(v[i], 1'b1);
      drain();
      got = q[0].pop_front();
      `CHK("byte", v[i], got)
      `CHK("starts", i + 1, cnt[0][0])
      `CHK("stops", i + 1, cnt[0][1])
      `CHK("in frame", 1'b0, fr[0])
    end
    // The leading byte stands for the mode byte that picks the increment behaviour.
    put(w[0], 1'b0);
    put(w[1], 1'b0);
    put(w[2], 1'b1);
    drain();
    `CHK("burst starts", 5, cnt[0][0])
    `CHK("burst stops", 5, cnt[0][1])
    `CHK("burst size", 3, q[0].size())
    for (int i = 0; i < 3; i++)
    begin
      got = q[0].pop_front();
      `CHK("burst byte", w[i], got)
    end
    `CHK("ninth", 0, cnt[0][2])
  endtask : t_master
  task automatic wire2(input logic c, input logic d, input int n);
    sc2 <= c;
    sd2 <= d;
    repeat (n) @(posedge ref_clk);
  endtask : wire2
  // The clock falls before data moves, so no sample sees both change at once.
  // One bit takes eight reference cycles, a 64 ns link clock.
  task automatic bit2(input logic b);
    wire2(1'b0, sd2, 2);
    wire2(1'b0, b, 2);
    wire2(1'b1, b, 4);
  endtask : bit2
  task automatic byte2(input logic [7:0] b, input logic nine);
    for (int i = 7; i >= 0; i--) bit2(b[i]);
    bit2(nine);
  endtask : byte2
  task automatic t_fault;
    logic [7:0] got;
    bit2(1'b0);
    wire2(1'b1, 1'b1, 4);
    repeat (4) @(posedge ref_clk);
    `CHK("stray stop", 0, cnt[1][1])
    `CHK("stray byte", 0, q[1].size())
    wire2(1'b1, 1'b0, 4);
    `CHK("in frame", 1'b1, fr[1])
    byte2(8'hC3, 1'b0);
    byte2(8'h81, 1'b1);
    bit2(1'b0);
    wire2(1'b1, 1'b1, 4);
    repeat (4) @(posedge ref_clk);
    `CHK("start", 1, cnt[1][0])
    `CHK("stop", 1, cnt[1][1])
    `CHK("out of frame", 1'b0, fr[1])
    `CHK("ninth low", 1, cnt[1][2])
    `CHK("fault size", 2, q[1].size())
    got = q[1].pop_front();
    `CHK("first", 8'hC3, got)
    got = q[1].pop_front();
    `CHK("second", 8'h81, got)
  endtask : t_fault
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_master();
    t_fault();
    report_and_stop();
  end
  // The tests need about 17 us, so only a hang reaches this limit.
  initial
  begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_ufm_write_only_serial_receiver
